// ### rtl/dpram_host_pkg.sv
// constants and types for the dual-port ram port controller
package dpram_host_pkg;
	localparam int DATA_W = 18;
	localparam int ADDR_W = 13;
	localparam int TOKEN_ADDR_W = 3;
	localparam int CLK_MHZ = 10;
	localparam int SYNC_STAGES = 2;

	// times in ns; the slowest speed grade is assumed
	localparam int ACCESS_NS = 55;
	localparam int FLOW_NS = 55;
	localparam int BUSY_SETTLE_NS = 55;
	localparam int DESELECT_NS = 55;

	// least time in ns to whole cycles, never below one
	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int ACCESS_CYC = ns_to_cycles(ACCESS_NS);
	localparam int FLOW_CYC = ns_to_cycles(FLOW_NS);
	localparam int SETTLE_CYC = ns_to_cycles(BUSY_SETTLE_NS);
	localparam int DESELECT_CYC = ns_to_cycles(DESELECT_NS);
	localparam int CNT_W = 8;

	// mailbox words of the 8K array
	localparam logic [ADDR_W-1:0] MBOX_RIGHT = 13'h1FFF;
	localparam logic [ADDR_W-1:0] MBOX_LEFT = 13'h1FFE;

	// own register map, byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA = 8'h08;
	localparam logic [7:0] OFS_RDATA = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// control fields
	localparam int CTRL_START = 0;
	localparam int CTRL_WRITE = 1;
	localparam int CTRL_TOKEN = 2;
	localparam int CTRL_LOWER = 4;
	localparam int CTRL_UPPER = 5;
	localparam int CTRL_MASTER = 8;
	localparam logic [8:0] CTRL_RESET = 9'h130;

	// status fields
	localparam int ST_ACTIVE = 0;
	localparam int ST_DONE = 1;
	localparam int ST_MBOX = 2;
	localparam int ST_BUSY_PIN = 3;
	localparam int ST_CONTEND = 4;

	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_SETTLE  = 3'b001,
		S_STROBE  = 3'b010,
		S_RELEASE = 3'b011
	} state_type;
endpackage

// ### rtl/pin_sync.sv
// two-flop synchroniser for inputs from the ram pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] rst_val,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_type;

	sync_type s_q;
	sync_type s_d;

	// first stage feeds only the second
	always_comb begin
		s_d = s_q;
		s_d.meta = async_in;
		s_d.stable = s_q.meta;
	end

	// reset loads the idle level of the pin
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '{meta: rst_val, stable: rst_val};
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule
`default_nettype wire

// ### rtl/dpram_port_ctrl.sv
// controller driving one port of the dual-port ram, with an ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
module dpram_port_ctrl (
	input  wire logic                                ref_clk,
	input  wire logic                                rst,
	// ahb-lite slave
	input  wire logic                                hsel,
	input  wire logic [31:0]                         haddr,
	input  wire logic [1:0]                          htrans,
	input  wire logic                                hwrite,
	input  wire logic [2:0]                          hsize,
	input  wire logic [31:0]                         hwdata,
	input  wire logic                                hready,
	output logic                                     hreadyout,
	output logic      [31:0]                         hrdata,
	output logic                                     hresp,
	// ram port pins
	output logic                                     ce_n,
	output logic                                     rw_n,
	output logic                                     oe_n,
	output logic                                     token_latch_select_n,
	output logic                                     upper_byte_lane_n,
	output logic                                     lower_byte_lane_n,
	output logic      [dpram_host_pkg::ADDR_W-1:0]   addr,
	output logic      [dpram_host_pkg::DATA_W-1:0]   data_out,
	output logic                                     data_oe,
	input  wire logic [dpram_host_pkg::DATA_W-1:0]   data_in,
	input  wire logic                                mbox_flag_n,
	input  wire logic                                busy_n,
	output logic                                     master_role
);
	typedef struct packed {
		dpram_host_pkg::state_type          st;
		logic [dpram_host_pkg::CNT_W-1:0]   cnt;
		logic [8:0]                         ctrl;
		logic [dpram_host_pkg::ADDR_W-1:0]  addr_reg;
		logic [dpram_host_pkg::DATA_W-1:0]  wdata;
		logic [dpram_host_pkg::DATA_W-1:0]  rdata;
		logic                               done;
		logic                               contend;
		logic                               op_write;
		logic                               op_token;
		logic                               ce_n;
		logic                               rw_n;
		logic                               oe_n;
		logic                               tok_n;
		logic                               ub_n;
		logic                               lb_n;
		logic [dpram_host_pkg::ADDR_W-1:0]  pin_addr;
		logic [dpram_host_pkg::DATA_W-1:0]  pin_data;
		logic                               pin_oe;
		logic                               dp_wr;
		logic [7:0]                         dp_ofs;
		logic [31:0]                        hrdata;
	} ctrl_state_type;

	ctrl_state_type r_q;
	ctrl_state_type r_d;

	logic [dpram_host_pkg::DATA_W-1:0] data_s;
	logic                              mbox_s_n;
	logic                              busy_s_n;

	// pins from the ram run on no clock of ours
	pin_sync #(.W(dpram_host_pkg::DATA_W + 2)) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in ({data_in, mbox_flag_n, busy_n}),
		.rst_val  ({{dpram_host_pkg::DATA_W{1'b0}}, 2'b11}),
		.sync_out ({data_s, mbox_s_n, busy_s_n})
	);

	function automatic logic [dpram_host_pkg::CNT_W-1:0] cyc(input int n);
		return n[dpram_host_pkg::CNT_W-1:0];
	endfunction

	function automatic logic [31:0] read_mux(input ctrl_state_type r, input logic [7:0] ofs,
			input logic mbox_n, input logic bsy_n);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (ofs)
			dpram_host_pkg::OFS_CTRL: v[8:0] = r.ctrl;
			dpram_host_pkg::OFS_ADDR: v[dpram_host_pkg::ADDR_W-1:0] = r.addr_reg;
			dpram_host_pkg::OFS_WDATA: v[dpram_host_pkg::DATA_W-1:0] = r.wdata;
			dpram_host_pkg::OFS_RDATA: v[dpram_host_pkg::DATA_W-1:0] = r.rdata;
			dpram_host_pkg::OFS_STATUS: begin
				v[dpram_host_pkg::ST_ACTIVE] = (r.st != dpram_host_pkg::S_IDLE);
				v[dpram_host_pkg::ST_DONE] = r.done;
				v[dpram_host_pkg::ST_MBOX] = ~mbox_n;
				v[dpram_host_pkg::ST_BUSY_PIN] = ~bsy_n;
				v[dpram_host_pkg::ST_CONTEND] = r.contend;
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	logic addr_phase;
	logic start_req;
	logic done_set;
	logic [8:0] ctrl_new;

	assign addr_phase = hsel & htrans[1] & hready;

	always_comb begin
		r_d = r_q;
		done_set = 1'b0;
		start_req = 1'b0;
		ctrl_new = hwdata[8:0];

		// address phase: latch the target, prefetch read data so hrdata comes from a flop
		r_d.dp_wr = addr_phase & hwrite;
		if (addr_phase) begin
			r_d.dp_ofs = haddr[7:0];
			r_d.hrdata = read_mux(r_q, haddr[7:0], mbox_s_n, busy_s_n);
		end

		// data phase of a write
		if (r_q.dp_wr) begin
			case (r_q.dp_ofs)
				dpram_host_pkg::OFS_CTRL: begin
					r_d.ctrl = ctrl_new;
					r_d.ctrl[dpram_host_pkg::CTRL_START] = 1'b0;
					start_req = ctrl_new[dpram_host_pkg::CTRL_START];
				end
				dpram_host_pkg::OFS_ADDR: r_d.addr_reg = hwdata[dpram_host_pkg::ADDR_W-1:0];
				dpram_host_pkg::OFS_WDATA: r_d.wdata = hwdata[dpram_host_pkg::DATA_W-1:0];
				dpram_host_pkg::OFS_STATUS: begin
					// write one to clear sticky bits
					if (hwdata[dpram_host_pkg::ST_DONE]) begin
						r_d.done = 1'b0;
					end
					if (hwdata[dpram_host_pkg::ST_CONTEND]) begin
						r_d.contend = 1'b0;
					end
				end
				default: ;
			endcase
		end

		case (r_q.st)
			dpram_host_pkg::S_IDLE: begin
				if (start_req) begin
					r_d.op_write = ctrl_new[dpram_host_pkg::CTRL_WRITE];
					r_d.op_token = ctrl_new[dpram_host_pkg::CTRL_TOKEN];
					r_d.pin_oe = ctrl_new[dpram_host_pkg::CTRL_WRITE];
					if (ctrl_new[dpram_host_pkg::CTRL_TOKEN]) begin
						// token access: memory select stays high, lanes off
						r_d.tok_n = 1'b0;
						r_d.ub_n = 1'b1;
						r_d.lb_n = 1'b1;
						r_d.pin_addr = {{(dpram_host_pkg::ADDR_W-dpram_host_pkg::TOKEN_ADDR_W){1'b0}},
							r_q.addr_reg[dpram_host_pkg::TOKEN_ADDR_W-1:0]};
						r_d.pin_data = {{(dpram_host_pkg::DATA_W-1){1'b1}}, r_q.wdata[0]};
					end else begin
						r_d.ce_n = 1'b0;
						r_d.ub_n = ~ctrl_new[dpram_host_pkg::CTRL_UPPER];
						r_d.lb_n = ~ctrl_new[dpram_host_pkg::CTRL_LOWER];
						r_d.pin_addr = r_q.addr_reg;
						r_d.pin_data = r_q.wdata;
					end
					// let busy settle after the select before any strobe
					r_d.cnt = cyc(dpram_host_pkg::SETTLE_CYC + dpram_host_pkg::SYNC_STAGES);
					r_d.st = dpram_host_pkg::S_SETTLE;
				end
			end
			dpram_host_pkg::S_SETTLE: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else if (!busy_s_n && !r_q.op_token) begin
					// lost arbitration: hold the request until the winner lets go
					r_d.contend = 1'b1;
				end else begin
					if (r_q.op_write) begin
						r_d.rw_n = 1'b0;
						r_d.cnt = cyc(dpram_host_pkg::ACCESS_CYC);
					end else begin
						r_d.oe_n = 1'b0;
						// flow-through plus sync stages before sampling
						r_d.cnt = cyc(dpram_host_pkg::ACCESS_CYC + dpram_host_pkg::FLOW_CYC
							+ dpram_host_pkg::SYNC_STAGES);
					end
					r_d.st = dpram_host_pkg::S_STROBE;
				end
			end
			dpram_host_pkg::S_STROBE: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					// write closes on the strobe rise with data still driven
					r_d.rw_n = 1'b1;
					if (!r_q.op_write) begin
						r_d.rdata = data_s;
					end
					r_d.cnt = cyc(dpram_host_pkg::DESELECT_CYC);
					r_d.st = dpram_host_pkg::S_RELEASE;
				end
			end
			dpram_host_pkg::S_RELEASE: begin
				// everything off for the deselect gap, so a token read-back is valid
				r_d.ce_n = 1'b1;
				r_d.oe_n = 1'b1;
				r_d.tok_n = 1'b1;
				r_d.ub_n = 1'b1;
				r_d.lb_n = 1'b1;
				r_d.pin_oe = 1'b0;
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					done_set = 1'b1;
					r_d.st = dpram_host_pkg::S_IDLE;
				end
			end
			default: begin
				r_d.st = dpram_host_pkg::S_IDLE;
			end
		endcase

		// completion beats a same-cycle clear
		if (done_set) begin
			r_d.done = 1'b1;
		end
	end

	// all state but the pin synchroniser in one register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_q <= '0;
			r_q.st <= dpram_host_pkg::S_IDLE;
			r_q.ctrl <= dpram_host_pkg::CTRL_RESET;
			r_q.ce_n <= 1'b1;
			r_q.rw_n <= 1'b1;
			r_q.oe_n <= 1'b1;
			r_q.tok_n <= 1'b1;
			r_q.ub_n <= 1'b1;
			r_q.lb_n <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r_q.hrdata;
	assign ce_n = r_q.ce_n;
	assign rw_n = r_q.rw_n;
	assign oe_n = r_q.oe_n;
	assign token_latch_select_n = r_q.tok_n;
	assign upper_byte_lane_n = r_q.ub_n;
	assign lower_byte_lane_n = r_q.lb_n;
	assign addr = r_q.pin_addr;
	assign data_out = r_q.pin_data;
	assign data_oe = r_q.pin_oe;
	assign master_role = r_q.ctrl[dpram_host_pkg::CTRL_MASTER];
endmodule
`default_nettype wire

// ### tb/dpram_port_monitor.sv
// checker of the ram pin protocol driven by the port controller
`timescale 1ns/100ps
`default_nettype none
module dpram_port_monitor (
	input wire logic                              ref_clk,
	input wire logic                              rst,
	input wire logic                              ce_n,
	input wire logic                              rw_n,
	input wire logic                              oe_n,
	input wire logic                              token_latch_select_n,
	input wire logic [dpram_host_pkg::ADDR_W-1:0] addr,
	input wire logic [dpram_host_pkg::DATA_W-1:0] data_out,
	input wire logic                              data_oe,
	input wire logic                              busy_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// strobe low two cycles with data driven, then rises while still driven
	sequence s_wr_body;
		(!rw_n && data_oe) [*2] ##1 (rw_n && data_oe);
	endsequence
	AST_WR_SHAPE: assert property ($fell(rw_n) |-> s_wr_body)
		else $error("write strobe shape wrong");
	AST_WR_SEL: assert property (!rw_n |-> (ce_n ^ token_latch_select_n))
		else $error("write strobe without exactly one select");
	AST_RD_SEL: assert property (!oe_n |-> (ce_n ^ token_latch_select_n) && !data_oe)
		else $error("read without select or with data driven");
	AST_TOK_CE: assert property (!token_latch_select_n |-> ce_n)
		else $error("token select with memory select");
	AST_NO_FIGHT: assert property (!rw_n |-> oe_n)
		else $error("output enable during write");
	AST_DATA_HOLD: assert property (!rw_n |-> $stable(data_out))
		else $error("data moved during strobe");
	AST_ADDR_HOLD: assert property (!ce_n && !$past(ce_n) |-> $stable(addr))
		else $error("address moved while selected");
	AST_RD_HOLD: assert property ($fell(oe_n) |-> !oe_n [*4])
		else $error("read enable too short");
	// latency through the synchroniser is covered by eight cycles
	AST_BUSY_WAIT: assert property ((!ce_n && !busy_n) [*8] |-> !$fell(rw_n))
		else $error("write strobe while busy");
endmodule
bind dpram_port_ctrl dpram_port_monitor i_dpram_port_monitor (.ref_clk(ref_clk), .rst(rst), .ce_n(ce_n),
	.rw_n(rw_n), .oe_n(oe_n), .token_latch_select_n(token_latch_select_n), .addr(addr), .data_out(data_out),
	.data_oe(data_oe), .busy_n(busy_n));
`default_nettype wire

// ### tb/dpram_port_model.sv
// behavioural model of one ram port: memory, mailbox, busy, token latches
`timescale 1ns/100ps
`default_nettype none
module dpram_port_model (
	input  wire logic        ref_clk,
	input  wire logic        ce_n,
	input  wire logic        rw_n,
	input  wire logic        oe_n,
	input  wire logic        token_latch_select_n,
	input  wire logic        upper_byte_lane_n,
	input  wire logic        lower_byte_lane_n,
	input  wire logic [12:0] addr,
	input  wire logic [17:0] data_out,
	input  wire logic        peer_mail,
	input  wire logic        peer_hold,
	input  wire logic [12:0] peer_addr,
	input  wire logic [7:0]  peer_tok,
	output logic      [17:0] data_in,
	output logic             mbox_flag_n,
	output logic             busy_n
);
	logic [17:0] mem [8192];
	logic [7:0]  own_q = 8'hFF;
	logic [17:0] junk_q = 18'h2AAAA;
	logic        flag_q = 1'h1;
	logic        rd;
	logic        lo;
	logic        hi;
	logic [17:0] val;
	// busy while the peer holds our word and we select it; released when the peer lets go or we deselect
	assign busy_n = !(peer_hold && !ce_n && addr == peer_addr);
	assign mbox_flag_n = flag_q;
	assign rd = !oe_n && (!ce_n || !token_latch_select_n);
	assign val = !token_latch_select_n ? {18{own_q[addr[2:0]]}} : mem[addr];
	assign lo = rd && (!lower_byte_lane_n || !token_latch_select_n);
	assign hi = rd && (!upper_byte_lane_n || !token_latch_select_n);
	// released lanes toggle every cycle so stale data never passes
	assign data_in = {hi ? val[17:9] : junk_q[17:9], lo ? val[8:0] : junk_q[8:0]};
	// write lands on strobe rise; a busy port cannot alter the word
	always @(posedge rw_n) begin
		if (!ce_n && busy_n && !lower_byte_lane_n) mem[addr][8:0] <= data_out[8:0];
		if (!ce_n && busy_n && !upper_byte_lane_n) mem[addr][17:9] <= data_out[17:9];
		// pending requests behind a peer owner are not modelled
		if (!token_latch_select_n) own_q[addr[2:0]] <= data_out[0] | peer_tok[addr[2:0]];
	end
	// peer writes raise our flag; our own unblocked read of MBOX_LEFT clears it
	always @(posedge ref_clk) begin
		junk_q <= ~junk_q;
		if (peer_mail) flag_q <= 1'h0;
		else if (rd && !ce_n && addr == dpram_host_pkg::MBOX_LEFT && busy_n) flag_q <= 1'h1;
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench of the ram port controller against a port model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        ref_clk = 1'h0;
	logic        rst = 1'h1;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0;
	logic        peer_mail = 1'h0;
	logic        peer_hold = 1'h0;
	logic [12:0] peer_addr = 13'h0;
	logic [7:0]  peer_tok = 8'h0;
	logic [31:0] rv;
	logic [31:0] got;
	logic [31:0] exp_q [$];
	logic [12:0] ta [4];
	logic [17:0] td [4];
	int          seed = 34;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          i;
	event        got_ev;
	wire logic [31:0] hrdata;
	wire logic        hreadyout, ce_n, rw_n, oe_n, token_latch_select_n, upper_byte_lane_n, lower_byte_lane_n;
	wire logic        data_oe, mbox_flag_n, busy_n;
	wire logic        master_role, hresp;
	wire logic [12:0] addr;
	wire logic [17:0] data_out, data_in;

	dpram_port_ctrl i_dpram_port_ctrl (.ref_clk(ref_clk), .rst(rst), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n),
		.token_latch_select_n(token_latch_select_n), .upper_byte_lane_n(upper_byte_lane_n),
		.lower_byte_lane_n(lower_byte_lane_n), .addr(addr), .data_out(data_out), .data_oe(data_oe),
		.data_in(data_in), .mbox_flag_n(mbox_flag_n), .busy_n(busy_n), .master_role(master_role));
	dpram_port_model i_dpram_port_model (.ref_clk(ref_clk), .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n),
		.token_latch_select_n(token_latch_select_n), .upper_byte_lane_n(upper_byte_lane_n),
		.lower_byte_lane_n(lower_byte_lane_n), .addr(addr), .data_out(data_out), .peer_mail(peer_mail),
		.peer_hold(peer_hold), .peer_addr(peer_addr), .peer_tok(peer_tok), .data_in(data_in),
		.mbox_flag_n(mbox_flag_n), .busy_n(busy_n));

	initial forever #50 ref_clk = ~ref_clk;

	task finish_test;
		if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task cmp(input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t exp %h got %h", $time, e, g);
		end
	endtask
	// one single transfer; waits on hready, never on a fixed count
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		rv = hrdata;
	endtask
	task chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back(e & m);
		bus(1'h0, a, 32'h0);
		got = rv & m;
		-> got_ev;
	endtask
	// pin level note; caller must block before the next note so the compare runs first
	task pin(input logic [31:0] e, input logic [31:0] g);
		exp_q.push_back(e);
		got = g;
		-> got_ev;
	endtask
	always @(got_ev) cmp(exp_q.pop_front(), got);
	// start one ram access, poll until done, then clear done
	task op(input logic [8:0] c, input logic [12:0] a, input logic [17:0] d);
		int k;
		bus(1'h1, 8'h04, {19'h0, a});
		bus(1'h1, 8'h08, {14'h0, d});
		bus(1'h1, 8'h00, {23'h0, c});
		k = 0;
		do begin bus(1'h0, 8'h10, 32'h0); k++; end while (rv[1] !== 1'h1 && k < 300);
		// a poll that runs out must count as a failure
		pin(32'h2, rv & 32'h2);
		bus(1'h1, 8'h10, 32'h2);
	endtask

	// hang guard, far above the several hundred cycles needed
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			finish_test;
		end
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		pin(32'h1, {30'h0, hresp, master_role});
		chk(8'h00, 32'h1FF, 32'h130);
		chk(8'h10, 32'h1F, 32'h0);
		bus(1'h1, 8'h0C, 32'hFFFF);
		chk(8'h0C, 32'hFFFFFFFF, 32'h0);
		chk(8'h14, 32'hFFFFFFFF, 32'h0);
		for (i = 0; i < 4; i++) begin
			ta[i] = {1'h0, 2'(i), 10'($random(seed))};
			td[i] = 18'($random(seed));
			op(9'h133, ta[i], td[i]);
		end
		for (i = 0; i < 4; i++) begin
			op(9'h131, ta[i], 18'h0);
			chk(8'h0C, 32'h3FFFF, {14'h0, td[i]});
		end
		op(9'h133, 13'h0123, 18'h3FFFF);
		op(9'h113, 13'h0123, 18'h0);
		op(9'h131, 13'h0123, 18'h0);
		chk(8'h0C, 32'h3FFFF, 32'h3FE00);
		op(9'h123, 13'h0123, 18'h0);
		op(9'h131, 13'h0123, 18'h0);
		chk(8'h0C, 32'h3FFFF, 32'h0);
		// role pin follows the control word once it lands
		bus(1'h1, 8'h00, 32'h30);
		@(posedge ref_clk);
		pin(32'h0, {30'h0, hresp, master_role});
		op(9'h133, dpram_host_pkg::MBOX_RIGHT, 18'h155);
		peer_mail <= 1'h1;
		@(posedge ref_clk);
		peer_mail <= 1'h0;
		repeat (4) @(posedge ref_clk);
		chk(8'h10, 32'h4, 32'h4);
		op(9'h131, dpram_host_pkg::MBOX_RIGHT, 18'h0);
		chk(8'h0C, 32'h3FFFF, 32'h155);
		chk(8'h10, 32'h4, 32'h4);
		op(9'h131, dpram_host_pkg::MBOX_LEFT, 18'h0);
		chk(8'h10, 32'h4, 32'h0);
		peer_addr <= 13'h0456;
		peer_hold <= 1'h1;
		fork
			op(9'h133, 13'h0456, 18'h2BCDE);
			begin repeat (40) @(posedge ref_clk); peer_hold <= 1'h0; end
		join
		chk(8'h10, 32'h10, 32'h10);
		op(9'h131, 13'h0456, 18'h0);
		chk(8'h0C, 32'h3FFFF, 32'h2BCDE);
		op(9'h137, 13'h1FFD, 18'h0);
		op(9'h135, 13'h0005, 18'h0);
		chk(8'h0C, 32'h3FFFF, 32'h0);
		peer_tok <= 8'h04;
		op(9'h137, 13'h0002, 18'h0);
		op(9'h135, 13'h0002, 18'h0);
		chk(8'h0C, 32'h3FFFF, 32'h3FFFF);
		// let the compare process take the last note before the verdict
		repeat (2) @(posedge ref_clk);
		finish_test;
	end
endmodule
`default_nettype wire
